/* mmps_pkg.sv */
// constants and types for the multi-motor pump staging block
package mmps_pkg;
// How it works
// [R1] staging and its outputs act only while the application mode register holds 3.
// [R2] aux motors start in rotating order from the first-aux selection, so selection 2 of three gives slot 2, 3, 0.
// [R3] aux motors drop in reverse start order, last started first dropped.
// [R4] the count of running aux motors is readable.
// [R5] the next aux starts only when frequency is above its start frequency, the start delay is over and the error is below the band.
// [R6] an aux stops only when frequency is below its stop frequency, the stop delay is over and the error exceeds the band.
// [R7] on an aux start PID is held and the main motor ramps down to that motor's stop frequency over the decel time.
// [R8] on an aux stop PID is held and the main motor ramps up to the start frequency over the accel time.
// [R9] rotation mode 0 always starts at the selected first aux and never rotates.
// [R10] rotation mode 1 flags rotation once the cumulative run time exceeds the rotation time.
// [R11] in aux rotation a stop or sleep after the flag advances the first aux selection by one with wrap.
// [R12] in main rotation the flag is set by the run time of the drive-connected motor.
// [R13] in main rotation the drive feeds the selected motor and the others stage cyclically after it.
// [R14] in main rotation a stop in the flag condition moves the drive to the next motor and shifts the order.
// [R15] rotation mode 2 selects main rotation sharing the outputs in motor order.
// [R16] the aux count accepts 0 to 4 and staging never runs more aux motors than it; lowering it while running only blocks further starts.
// [R17] start and stop delay timers restart whenever their condition drops before completion.
    localparam int          MMPS_MOTORS      = 4;
    localparam logic [1:0]  MMPS_ROT_NONE    = 2'h0;
    localparam logic [1:0]  MMPS_ROT_AUX     = 2'h1;
    localparam logic [1:0]  MMPS_ROT_MAIN    = 2'h2;
    localparam logic [3:0]  MMPS_APP_STAGING = 4'h3;
    localparam logic [2:0]  MMPS_AUX_MAX     = 3'h4;
    // register byte addresses
    localparam logic [7:0]  MMPS_A_CTRL      = 8'h00;
    localparam logic [7:0]  MMPS_A_SEL       = 8'h04;
    localparam logic [7:0]  MMPS_A_START_F   = 8'h08;
    localparam logic [7:0]  MMPS_A_STOP_F    = 8'h0c;
    localparam logic [7:0]  MMPS_A_DELAY     = 8'h10;
    localparam logic [7:0]  MMPS_A_RAMP      = 8'h14;
    localparam logic [7:0]  MMPS_A_ROT_TIME  = 8'h18;
    localparam logic [7:0]  MMPS_A_BAND      = 8'h1c;
    localparam logic [7:0]  MMPS_A_STATUS    = 8'h20;
    // reset values, times in tenths of a second, minutes, hundredths of Hz
    localparam logic [7:0]  MMPS_RST_START_F = 8'hc8;
    localparam logic [7:0]  MMPS_RST_STOP_F  = 8'h3c;
    localparam logic [15:0] MMPS_RST_DELAY   = 16'h0258;
    localparam logic [15:0] MMPS_RST_RAMP    = 16'h0014;
    localparam logic [15:0] MMPS_RST_ROT     = 16'h10e0;
    localparam logic [7:0]  MMPS_RST_BAND    = 8'h02;
    localparam int          MMPS_CLK_HZ      = 20000000;
    localparam int          MMPS_TICK_MS     = 100;
    localparam int          MMPS_TICK_CYC    = MMPS_CLK_HZ / 1000 * MMPS_TICK_MS;
    localparam int          MMPS_MIN_TICKS   = 600;
    typedef enum logic [1:0] {MMPS_IDLE, MMPS_RUN, MMPS_RAMP_DN, MMPS_RAMP_UP} mmps_state_t;
endpackage : mmps_pkg

/* mmps_tick.sv */
// periodic strobe divider
`timescale 1ns/1ps
`default_nettype none
module mmps_tick #(
    parameter int PERIOD = 2000000
) (
    input  wire logic pclk,
    input  wire logic presetn,
    output logic      tick
);
    logic [31:0] cnt_q;
    logic [31:0] cnt_d;
    always_comb
    begin
        cnt_d = cnt_q + 32'h1;
        if (cnt_q == 32'(PERIOD - 1))
        begin
            cnt_d = '0;
        end
    end
    always_ff @(posedge pclk or negedge presetn)
    begin
        if (!presetn)
        begin
            cnt_q <= '0;
        end
        else
        begin
            cnt_q <= cnt_d;
        end
    end
    assign tick = (cnt_q == 32'(PERIOD - 1));
endmodule // mmps_tick
`default_nettype wire

/* mmps_delay.sv */
// condition-qualified delay timer counting ticks
`timescale 1ns/1ps
`default_nettype none
module mmps_delay (
    input  wire logic        pclk,
    input  wire logic        presetn,
    input  wire logic        tick,
    input  wire logic        cond,
    input  wire logic        clear,
    input  wire logic [15:0] limit,
    output logic             done
);
    logic [15:0] cnt_q;
    logic [15:0] cnt_d;
    always_comb
    begin
        cnt_d = cnt_q;
        // [R17] restart on lost condition
        if (!cond || clear)
        begin
            cnt_d = '0;
        end
        else if (tick && cnt_q < limit)
        begin
            cnt_d = cnt_q + 16'h1;
        end
    end
    always_ff @(posedge pclk or negedge presetn)
    begin
        if (!presetn)
        begin
            cnt_q <= '0;
        end
        else
        begin
            cnt_q <= cnt_d;
        end
    end
    assign done = cond && (cnt_q >= limit);
endmodule // mmps_delay
`default_nettype wire

/* mmps_top.sv */
// pump staging sequencer with apb registers
//
// Added by the designer: the placing of the registers and register access over APB.
`timescale 1ns/1ps
`default_nettype none
module mmps_top
    import mmps_pkg::*;
#(
    parameter int TICK_CYC = mmps_pkg::MMPS_TICK_CYC
) (
    input  wire logic        pclk,
    input  wire logic        presetn,
    input  wire logic        psel,
    input  wire logic        penable,
    input  wire logic        pwrite,
    input  wire logic [7:0]  paddr,
    input  wire logic [31:0] pwdata,
    output logic [31:0]      prdata,
    output logic             pready,
    output logic             pslverr,
    input  wire logic        run_cmd,
    input  wire logic [7:0]  main_freq,
    input  wire logic [7:0]  pid_error,
    output logic [3:0]       motor_aux_on,
    output logic [3:0]       motor_on_drive,
    output logic             pid_hold,
    output logic [7:0]       ramp_target,
    output logic [15:0]      ramp_time,
    output logic [2:0]       running_aux_count,
    output logic             rotation_flag
);
    import mmps_pkg::*;
    logic        run_s1_q, run_s2_q;
    logic [7:0]  freq_s1_q, freq_s2_q, err_s1_q, err_s2_q;
    always_ff @(posedge pclk or negedge presetn)
    begin
        if (!presetn)
        begin
            run_s1_q  <= 1'b0;
            run_s2_q  <= 1'b0;
            freq_s1_q <= '0;
            freq_s2_q <= '0;
            err_s1_q  <= '0;
            err_s2_q  <= '0;
        end
        else
        begin
            run_s1_q  <= run_cmd;
            run_s2_q  <= run_s1_q;
            freq_s1_q <= main_freq;
            freq_s2_q <= freq_s1_q;
            err_s1_q  <= pid_error;
            err_s2_q  <= err_s1_q;
        end
    end

    // configuration registers
    logic [3:0]  app_mode_q, app_mode_d;
    logic [1:0]  rot_mode_q, rot_mode_d;
    logic [2:0]  aux_count_select_q, aux_count_select_d;
    logic [1:0]  first_aux_select_q, first_aux_select_d;
    logic [31:0] aux_start_freq_q, aux_start_freq_d;
    logic [31:0] aux_stop_freq_q, aux_stop_freq_d;
    logic [15:0] aux_start_delay_q, aux_start_delay_d;
    logic [15:0] aux_stop_delay_q, aux_stop_delay_d;
    logic [15:0] staging_accel_time_q, staging_accel_time_d;
    logic [15:0] staging_decel_time_q, staging_decel_time_d;
    logic [15:0] rotation_time_q, rotation_time_d;
    logic [7:0]  pressure_diff_band_q, pressure_diff_band_d;
    logic        wr_en, adv_sel;
    logic [1:0]  sel_next;

    assign wr_en   = psel && penable && pwrite;
    assign pready  = 1'b1;

    function automatic logic [1:0] mmps_wrap(input logic [1:0] v, input logic [1:0] add);
        mmps_wrap = v + add;
    endfunction

    always_comb
    begin
        app_mode_d           = app_mode_q;
        rot_mode_d           = rot_mode_q;
        aux_count_select_d   = aux_count_select_q;
        first_aux_select_d   = first_aux_select_q;
        aux_start_freq_d     = aux_start_freq_q;
        aux_stop_freq_d      = aux_stop_freq_q;
        aux_start_delay_d    = aux_start_delay_q;
        aux_stop_delay_d     = aux_stop_delay_q;
        staging_accel_time_d = staging_accel_time_q;
        staging_decel_time_d = staging_decel_time_q;
        rotation_time_d      = rotation_time_q;
        pressure_diff_band_d = pressure_diff_band_q;
        if (wr_en && paddr == MMPS_A_CTRL)
        begin
            app_mode_d = pwdata[3:0];
            rot_mode_d = (pwdata[5:4] > MMPS_ROT_MAIN) ? MMPS_ROT_NONE : pwdata[5:4];
            // [R16] clamp aux count
            aux_count_select_d = (pwdata[10:8] > MMPS_AUX_MAX) ? MMPS_AUX_MAX : pwdata[10:8];
        end
        else if (wr_en && paddr == MMPS_A_SEL)
        begin
            first_aux_select_d = pwdata[1:0];
        end
        else if (wr_en && paddr == MMPS_A_START_F)
        begin
            aux_start_freq_d = pwdata;
        end
        else if (wr_en && paddr == MMPS_A_STOP_F)
        begin
            aux_stop_freq_d = pwdata;
        end
        else if (wr_en && paddr == MMPS_A_DELAY)
        begin
            aux_start_delay_d = pwdata[15:0];
            aux_stop_delay_d  = pwdata[31:16];
        end
        else if (wr_en && paddr == MMPS_A_RAMP)
        begin
            staging_accel_time_d = pwdata[15:0];
            staging_decel_time_d = pwdata[31:16];
        end
        else if (wr_en && paddr == MMPS_A_ROT_TIME)
        begin
            rotation_time_d = pwdata[15:0];
        end
        else if (wr_en && paddr == MMPS_A_BAND)
        begin
            pressure_diff_band_d = pwdata[7:0];
        end
        // [R11] advance selection with wrap; hardware wins over a same-cycle write
        if (adv_sel)
        begin
            first_aux_select_d = sel_next;
        end
    end

    always_ff @(posedge pclk or negedge presetn)
    begin
        if (!presetn)
        begin
            app_mode_q           <= '0;
            rot_mode_q           <= MMPS_ROT_NONE;
            aux_count_select_q   <= MMPS_AUX_MAX;
            first_aux_select_q   <= '0;
            aux_start_freq_q     <= {4{MMPS_RST_START_F}};
            aux_stop_freq_q      <= {4{MMPS_RST_STOP_F}};
            aux_start_delay_q    <= MMPS_RST_DELAY;
            aux_stop_delay_q     <= MMPS_RST_DELAY;
            staging_accel_time_q <= MMPS_RST_RAMP;
            staging_decel_time_q <= MMPS_RST_RAMP;
            rotation_time_q      <= MMPS_RST_ROT;
            pressure_diff_band_q <= MMPS_RST_BAND;
        end
        else
        begin
            app_mode_q           <= app_mode_d;
            rot_mode_q           <= rot_mode_d;
            aux_count_select_q   <= aux_count_select_d;
            first_aux_select_q   <= first_aux_select_d;
            aux_start_freq_q     <= aux_start_freq_d;
            aux_stop_freq_q      <= aux_stop_freq_d;
            aux_start_delay_q    <= aux_start_delay_d;
            aux_stop_delay_q     <= aux_stop_delay_d;
            staging_accel_time_q <= staging_accel_time_d;
            staging_decel_time_q <= staging_decel_time_d;
            rotation_time_q      <= rotation_time_d;
            pressure_diff_band_q <= pressure_diff_band_d;
        end
    end

    // staging state
    mmps_state_t state_q, state_d;
    logic [2:0]  cnt_q, cnt_d;
    logic [15:0] run_min_q, run_min_d;
    logic [9:0]  min_tick_q, min_tick_d;
    logic        rot_q, rot_d;
    logic        enabled, tick, stage_up, stage_dn, start_ok, stop_ok;
    logic [1:0]  base, up_slot, dn_slot;
    logic [7:0]  up_start_f, up_stop_f, dn_stop_f;
    logic [2:0]  max_aux;

    mmps_tick #(.PERIOD(TICK_CYC)) u_tick (
        .pclk    (pclk),
        .presetn (presetn),
        .tick    (tick)
    );

    // [R1] active only in staging application mode
    assign enabled = (app_mode_q == MMPS_APP_STAGING) && run_s2_q;
    // [R13] main rotation: aux slots begin after the drive motor
    assign base    = (rot_mode_q == MMPS_ROT_MAIN) ? mmps_wrap(first_aux_select_q, 2'h1)
                                                   : first_aux_select_q;
    // main rotation uses one motor for the drive, so an aux count of 4 is cut to 3
    assign max_aux = (rot_mode_q == MMPS_ROT_MAIN && aux_count_select_q == MMPS_AUX_MAX)
                     ? (MMPS_AUX_MAX - 3'h1) : aux_count_select_q;
    // [R2] next started slot in cyclic order from the base
    assign up_slot = mmps_wrap(base, cnt_q[1:0]);
    // [R3] last started slot drops first
    assign dn_slot = mmps_wrap(base, cnt_q[1:0] - 2'h1);
    assign up_start_f = aux_start_freq_q[8*up_slot +: 8];
    assign up_stop_f  = aux_stop_freq_q[8*up_slot +: 8];
    assign dn_stop_f  = aux_stop_freq_q[8*dn_slot +: 8];

    // [R5] start conditions
    assign start_ok = enabled && state_q == MMPS_RUN && cnt_q < max_aux
                      && freq_s2_q > up_start_f && err_s2_q < pressure_diff_band_q;
    // [R6] stop conditions
    assign stop_ok  = enabled && state_q == MMPS_RUN && cnt_q != 3'h0
                      && freq_s2_q < dn_stop_f && err_s2_q > pressure_diff_band_q;

    mmps_delay u_start_dly (
        .pclk    (pclk),
        .presetn (presetn),
        .tick    (tick),
        .cond    (start_ok),
        .clear   (1'b0),
        .limit   (aux_start_delay_q),
        .done    (stage_up)
    );
    mmps_delay u_stop_dly (
        .pclk    (pclk),
        .presetn (presetn),
        .tick    (tick),
        .cond    (stop_ok),
        .clear   (1'b0),
        .limit   (aux_stop_delay_q),
        .done    (stage_dn)
    );

    logic [15:0] ramp_cnt_q, ramp_cnt_d;
    logic [7:0]  ramp_target_q, ramp_target_d;
    logic [15:0] ramp_time_q, ramp_time_d;

    always_comb
    begin
        state_d       = state_q;
        cnt_d         = cnt_q;
        ramp_cnt_d    = ramp_cnt_q;
        ramp_target_d = ramp_target_q;
        ramp_time_d   = ramp_time_q;
        case (state_q)
            MMPS_IDLE:
            begin
                cnt_d = '0;
                if (enabled)
                begin
                    state_d = MMPS_RUN;
                end
            end
            MMPS_RUN:
            begin
                if (!enabled)
                begin
                    state_d = MMPS_IDLE;
                end
                // [R7] ramp down to the new motor's stop frequency
                else if (stage_up)
                begin
                    cnt_d         = cnt_q + 3'h1;
                    ramp_target_d = up_stop_f;
                    ramp_time_d   = staging_decel_time_q;
                    ramp_cnt_d    = '0;
                    state_d       = MMPS_RAMP_DN;
                end
                // [R8] ramp up to the dropped motor's start frequency
                else if (stage_dn)
                begin
                    cnt_d         = cnt_q - 3'h1;
                    ramp_target_d = aux_start_freq_q[8*dn_slot +: 8];
                    ramp_time_d   = staging_accel_time_q;
                    ramp_cnt_d    = '0;
                    state_d       = MMPS_RAMP_UP;
                end
            end
            default:
            begin
                if (!enabled)
                begin
                    state_d = MMPS_IDLE;
                end
                else if (tick)
                begin
                    ramp_cnt_d = ramp_cnt_q + 16'h1;
                    if (ramp_cnt_q >= ramp_time_q)
                    begin
                        state_d = MMPS_RUN;
                    end
                end
            end
        endcase
    end

    always_ff @(posedge pclk or negedge presetn)
    begin
        if (!presetn)
        begin
            state_q       <= MMPS_IDLE;
            cnt_q         <= '0;
            ramp_cnt_q    <= '0;
            ramp_target_q <= '0;
            ramp_time_q   <= '0;
        end
        else
        begin
            state_q       <= state_d;
            cnt_q         <= cnt_d;
            ramp_cnt_q    <= ramp_cnt_d;
            ramp_target_q <= ramp_target_d;
            ramp_time_q   <= ramp_time_d;
        end
    end

    // run-time accounting in minutes
    always_comb
    begin
        min_tick_d = min_tick_q;
        run_min_d  = run_min_q;
        rot_d      = rot_q;
        adv_sel    = 1'b0;
        sel_next   = mmps_wrap(first_aux_select_q, 2'h1);
        if (enabled && tick)
        begin
            min_tick_d = min_tick_q + 10'h1;
            if (min_tick_q == 10'(MMPS_MIN_TICKS - 1))
            begin
                min_tick_d = '0;
                run_min_d  = run_min_q + 16'h1;
            end
        end
        // [R10] [R12] flag once run time exceeds rotation time
        if (rot_mode_q != MMPS_ROT_NONE && run_min_q > rotation_time_q)
        begin
            rot_d = 1'b1;
        end
        // [R9] mode 0 never rotates
        if (rot_mode_q == MMPS_ROT_NONE)
        begin
            rot_d = 1'b0;
        end
        // [R11] [R14] stop after flag shifts the order
        if (state_q != MMPS_IDLE && state_d == MMPS_IDLE && rot_q)
        begin
            adv_sel    = 1'b1;
            rot_d      = 1'b0;
            run_min_d  = '0;
            min_tick_d = '0;
        end
    end

    always_ff @(posedge pclk or negedge presetn)
    begin
        if (!presetn)
        begin
            min_tick_q <= '0;
            run_min_q  <= '0;
            rot_q      <= 1'b0;
        end
        else
        begin
            min_tick_q <= min_tick_d;
            run_min_q  <= run_min_d;
            rot_q      <= rot_d;
        end
    end

    // outputs
    logic [3:0] aux_on_d, aux_on_q, drive_d, drive_q;
    always_comb
    begin
        aux_on_d = '0;
        drive_d  = '0;
        for (int i = 0; i < MMPS_MOTORS; i++)
        begin
            if (3'(i) < cnt_q)
            begin
                aux_on_d[mmps_wrap(base, 2'(i))] = 1'b1;
            end
        end
        // [R15] main rotation puts drive on a motor output
        if (enabled && rot_mode_q == MMPS_ROT_MAIN)
        begin
            drive_d[first_aux_select_q] = 1'b1;
        end
    end
    always_ff @(posedge pclk or negedge presetn)
    begin
        if (!presetn)
        begin
            aux_on_q <= '0;
            drive_q  <= '0;
        end
        else
        begin
            aux_on_q <= aux_on_d;
            drive_q  <= drive_d;
        end
    end
    assign motor_aux_on      = aux_on_q;
    assign motor_on_drive    = drive_q;
    assign pid_hold          = (state_q == MMPS_RAMP_DN) || (state_q == MMPS_RAMP_UP);
    assign ramp_target       = ramp_target_q;
    assign ramp_time         = ramp_time_q;
    // [R4] running count
    assign running_aux_count = cnt_q;
    assign rotation_flag     = rot_q;

    // read mux, unmapped reads zero
    always_comb
    begin
        prdata  = '0;
        pslverr = 1'b0;
        if (paddr == MMPS_A_CTRL)
        begin
            prdata = {21'h0, aux_count_select_q, 2'h0, rot_mode_q, app_mode_q};
        end
        else if (paddr == MMPS_A_SEL)
        begin
            prdata = {30'h0, first_aux_select_q};
        end
        else if (paddr == MMPS_A_START_F)
        begin
            prdata = aux_start_freq_q;
        end
        else if (paddr == MMPS_A_STOP_F)
        begin
            prdata = aux_stop_freq_q;
        end
        else if (paddr == MMPS_A_DELAY)
        begin
            prdata = {aux_stop_delay_q, aux_start_delay_q};
        end
        else if (paddr == MMPS_A_RAMP)
        begin
            prdata = {staging_decel_time_q, staging_accel_time_q};
        end
        else if (paddr == MMPS_A_ROT_TIME)
        begin
            prdata = {16'h0, rotation_time_q};
        end
        else if (paddr == MMPS_A_BAND)
        begin
            prdata = {24'h0, pressure_diff_band_q};
        end
        else if (paddr == MMPS_A_STATUS)
        begin
            prdata = {run_min_q, 6'h0, state_q, 3'h0, rot_q, 1'b0, cnt_q};
        end
    end

    chk_count_bound: assert property (@(posedge pclk) disable iff (!presetn)
        cnt_q <= aux_count_select_q) else $error("aux count above limit"); // [R16]
    chk_idle_when_off: assert property (@(posedge pclk) disable iff (!presetn)
        !enabled |=> cnt_q == 3'h0 || state_q == MMPS_IDLE) else $error("staging while off"); // [R1]
    chk_start_cond: assert property (@(posedge pclk) disable iff (!presetn)
        (state_q == MMPS_RUN && state_d == MMPS_RAMP_DN) |-> freq_s2_q > up_start_f
        && err_s2_q < pressure_diff_band_q) else $error("start without conditions"); // [R5]
    chk_stop_cond: assert property (@(posedge pclk) disable iff (!presetn)
        (state_q == MMPS_RUN && state_d == MMPS_RAMP_UP) |-> freq_s2_q < dn_stop_f
        && err_s2_q > pressure_diff_band_q) else $error("stop without conditions"); // [R6]
    chk_up_count: assert property (@(posedge pclk) disable iff (!presetn)
        $rose(state_q == MMPS_RAMP_DN) |-> cnt_q == $past(cnt_q) + 3'h1) else $error("bad add"); // [R2]
    chk_dn_count: assert property (@(posedge pclk) disable iff (!presetn)
        $rose(state_q == MMPS_RAMP_UP) |-> cnt_q == $past(cnt_q) - 3'h1) else $error("bad drop"); // [R3]
    chk_decel_ramp: assert property (@(posedge pclk) disable iff (!presetn)
        $rose(state_q == MMPS_RAMP_DN) |-> pid_hold && ramp_time == staging_decel_time_q)
        else $error("decel ramp wrong"); // [R7]
    chk_accel_ramp: assert property (@(posedge pclk) disable iff (!presetn)
        $rose(state_q == MMPS_RAMP_UP) |-> pid_hold && ramp_time == staging_accel_time_q)
        else $error("accel ramp wrong"); // [R8]
    chk_no_rotate: assert property (@(posedge pclk) disable iff (!presetn)
        rot_mode_q == MMPS_ROT_NONE |=> !rot_q) else $error("rotation in mode 0"); // [R9]
    chk_sel_advance: assert property (@(posedge pclk) disable iff (!presetn)
        adv_sel |=> first_aux_select_q == $past(sel_next)) else $error("no advance"); // [R11]
    chk_count_out: assert property (@(posedge pclk) disable iff (!presetn)
        ##1 $countones(motor_aux_on) == 32'($past(cnt_q))) else $error("outputs vs count"); // [R4]
endmodule // mmps_top
`default_nettype wire

/* mmps_pump_model.sv */
// mains-fed auxiliary pumps behind the staging relays
`timescale 1ns/1ps
`default_nettype none
module mmps_pump_model (
    input  wire logic       pclk,
    input  wire logic [3:0] motor_aux_on,
    output logic [2:0]      pumps_spinning
);
    // contactors pick up one cycle after the relay command
    always_ff @(posedge pclk)
    begin
        pumps_spinning <= 3'($countones(motor_aux_on));
    end
endmodule // mmps_pump_model
`default_nettype wire

/* testbench.sv */
// self-checking bench for the pump staging block
`timescale 1ns/1ps
`default_nettype none
module testbench;
    import mmps_pkg::*;
    logic pclk = 0, presetn = 0, psel = 0, penable = 0, pwrite = 0, run_cmd = 0;
    logic [7:0]  paddr = 8'h00, main_freq = 8'h00, pid_error = 8'h00;
    logic [31:0] pwdata = 32'h0, prdata, rd;
    logic        pready, pid_hold, rotation_flag;
    logic [3:0]  motor_aux_on, motor_on_drive;
    logic [7:0]  ramp_target;
    logic [15:0] ramp_time;
    logic [2:0]  running_aux_count, pumps_spinning;
    logic [1:0]  sel;
    int          n_errors = 0, checks_done = 0;
    always #25 pclk = ~pclk;
    mmps_top #(.TICK_CYC(20)) dut (.pclk(pclk), .presetn(presetn), .psel(psel),
        .penable(penable), .pwrite(pwrite), .paddr(paddr), .pwdata(pwdata),
        .prdata(prdata), .pready(pready), .pslverr(), .run_cmd(run_cmd),
        .main_freq(main_freq), .pid_error(pid_error), .motor_aux_on(motor_aux_on),
        .motor_on_drive(motor_on_drive), .pid_hold(pid_hold), .ramp_target(ramp_target),
        .ramp_time(ramp_time), .running_aux_count(running_aux_count),
        .rotation_flag(rotation_flag));
    mmps_pump_model pumps (.pclk(pclk), .motor_aux_on(motor_aux_on),
        .pumps_spinning(pumps_spinning));
    function automatic logic [3:0] slot(input int k);
        return 4'h1 << ((sel + k) % 4);
    endfunction
    task automatic tally_and_finish;
        $display("checks %0d mismatches %0d", checks_done, n_errors);
        if (n_errors == 0 && checks_done > 0)
            $display("== PASSED ==");
        else
            $display("== FAILED ==");
        $finish;
    endtask
    task automatic chk(input string what, input logic [31:0] seen, input logic [31:0] exp);
        checks_done++;
        if (seen !== exp)
        begin
            n_errors++;
            $display("[FAIL] %s expected %h seen %h", what, exp, seen);
        end
    endtask
    task automatic apb(input logic w, input logic [7:0] a, input logic [31:0] d);
        int n;
        @(posedge pclk);
        psel <= 1; pwrite <= w; paddr <= a; pwdata <= d;
        @(posedge pclk);
        penable <= 1;
        n = 0;
        do
        begin
            @(posedge pclk);
            n++;
        end
        while (pready !== 1'b1 && n < 50);
        rd = prdata;
        psel <= 0; penable <= 0;
        if (n >= 50)
        begin
            n_errors++;
            tally_and_finish();
        end
    endtask
    task automatic wait_count(input logic [2:0] want);
        int n;
        for (n = 0; n < 3000 && running_aux_count !== want; n++)
            @(negedge pclk);
        // relay outputs are registered one cycle behind the count
        @(negedge pclk);
        if (n >= 3000)
        begin
            n_errors++;
            tally_and_finish();
        end
    endtask
    initial
    begin
        void'($urandom(84197));
        repeat (12) @(posedge pclk);
        presetn <= 1;
        apb(0, MMPS_A_CTRL, 0);     chk("ctrl", rd, 32'h400);
        apb(0, MMPS_A_START_F, 0);  chk("start_f", rd, 32'hc8c8c8c8);
        apb(0, 8'h24, 0);           chk("unmapped", rd, 32'h0);
        $display("test registers done");
        sel = 2'($urandom % 4);
        apb(1, MMPS_A_SEL, {30'h0, sel});
        apb(1, MMPS_A_DELAY, 32'h00010001);
        apb(1, MMPS_A_RAMP, 32'h00010001);
        apb(1, MMPS_A_CTRL, 32'h203);
        main_freq <= 8'he0 + 8'($urandom % 16); pid_error <= 8'h00; run_cmd <= 1;
        wait_count(1);
        chk("first", motor_aux_on, slot(0));
        chk("hold", pid_hold, 1'b1);
        chk("dn target", ramp_target, MMPS_RST_STOP_F);
        chk("dn time", ramp_time, 16'h1);
        wait_count(2);
        chk("second", motor_aux_on, slot(0) | slot(1));
        repeat (300) @(negedge pclk);
        chk("cap", running_aux_count, 3'h2);
        chk("pumps", pumps_spinning, 3'h2);
        $display("test staging up done");
        @(posedge pclk);
        main_freq <= 8'h10; pid_error <= 8'h80 + 8'($urandom % 64);
        wait_count(1);
        chk("drop", motor_aux_on, slot(0));
        chk("up hold", pid_hold, 1'b1);
        chk("up target", ramp_target, MMPS_RST_START_F);
        wait_count(0);
        $display("test staging down done");
        apb(1, MMPS_A_CTRL, 32'h200);
        main_freq <= 8'hf0; pid_error <= 8'h00;
        repeat (300) @(negedge pclk);
        chk("app off", running_aux_count, 3'h0);
        $display("test app mode done");
        apb(1, MMPS_A_ROT_TIME, 0);
        apb(1, MMPS_A_CTRL, 32'h213);
        repeat (12100) @(negedge pclk);
        chk("rot flag", rotation_flag, 1'b1);
        @(posedge pclk);
        run_cmd <= 0;
        repeat (6) @(posedge pclk);
        apb(0, MMPS_A_SEL, 0);
        chk("advance", rd, {30'h0, 2'(sel + 2'h1)});
        chk("flag clear", rotation_flag, 1'b0);
        $display("test aux rotation done");
        apb(1, MMPS_A_CTRL, 32'h423);
        run_cmd <= 1;
        wait_count(3);
        chk("drive", motor_on_drive, slot(1));
        chk("main aux", motor_aux_on, 4'hf ^ slot(1));
        repeat (12100) @(negedge pclk);
        @(posedge pclk);
        run_cmd <= 0;
        repeat (6) @(posedge pclk);
        run_cmd <= 1;
        wait_count(3);
        chk("next drive", motor_on_drive, slot(2));
        chk("next aux", motor_aux_on, 4'hf ^ slot(2));
        $display("test main rotation done");
        tally_and_finish();
    end
endmodule // testbench
`default_nettype wire
